/* token_mac_status_and_irq_ctrl.sv */
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "token_irq_regs.svh"

module token_mac_status_and_irq_ctrl
  import token_irq_pkg::*;
#(
  parameter int unsigned GAP_LONG_CYC = `GAP_LONG_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // register port
  input  wire logic [9:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o,
  // state reflected from the token engine (same clock)
  input  wire logic        early_ready_i,
  input  wire logic        recv_en_i,
  input  wire idle_sel_t   idle_sel_i,
  input  wire mac_state_t  mac_state_i,
  input  wire stn_type_t   stn_type_i,
  input  wire logic        conf_latched_i,
  input  wire logic        ind_latched_i,
  input  wire logic        high_prio_i,
  input  wire logic        sync_idle_sel_i,
  input  wire logic        gap_update_latched_i,
  input  wire logic        mem_lock_i,
  // event pulses, one per request bit
  input  wire logic [15:0] event_i,
  // interrupt pins
  output logic             common_irq_pin_o,
  output logic             ind_conf_irq_pin_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [15:0] req;
    logic [15:0] mask;
    logic [7:0]  mode0;
    logic [7:0]  mode2;
    logic [7:0]  rdata;
    logic        done;
    logic        common_pin;
    logic        ic_pin;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;

  logic        gap_busy;
  logic [15:0] active_irq;
  logic [15:0] status_word;
  logic [15:0] ic_route;
  logic        sep_mode;
  logic        common_any;
  logic        ic_any;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // status word

  assign status_word[7]     = early_ready_i;
  assign status_word[6]     = recv_en_i;
  assign status_word[5:4]   = idle_sel_i;
  // one bit per controller state, hold on bit 3 down to offline on bit 0
  for (genvar k = 0; k < 4; k++) begin : g_mac_bits
    assign status_word[3-k] = (mac_state_i == mac_state_t'(k));
  end
  assign status_word[15:14] = stn_type_i;
  assign status_word[13]    = conf_latched_i;
  assign status_word[12]    = ind_latched_i;
  assign status_word[11]    = high_prio_i;
  assign status_word[10]    = sync_idle_sel_i;
  assign status_word[9]     = gap_update_latched_i;
  assign status_word[8]     = mem_lock_i;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt routing

  // events are or-ed flat, no ordering and no vector
  assign active_irq = st_r.req & ~st_r.mask;
  assign sep_mode   = st_r.mode0[`MODE0_SEP_IRQ];
  assign ic_route   = sep_mode ? ((16'h0001 << `EVT_IND) | (16'h0001 << `EVT_CONF)) : 16'h0000;
  assign common_any = |(active_irq & ~ic_route);
  assign ic_any     = |(active_irq & ic_route);

  // done pulse restarts the inactive period
  irq_gap_timer #(
    .LONG_CYC (GAP_LONG_CYC)
  ) u_gap (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .start_i    (st_r.done),
    .long_sel_i (st_r.mode2[`MODE2_GAP_SEL]),
    .busy_o     (gap_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic        pol;
    set_v  = event_i;
    clr_v  = 16'h0000;
    pol    = st_r.mode0[`MODE0_POLARITY];
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (wr_i) begin
      unique case (addr_i)
        `ADDR_MASK_LO:  st_nxt.mask[7:0]  = wdata_i;
        `ADDR_MASK_HI:  st_nxt.mask[15:8] = wdata_i;
        `ADDR_ACK_LO:   clr_v[7:0]        = wdata_i;
        `ADDR_ACK_HI:   clr_v[15:8]       = wdata_i;
        `ADDR_FORCE_LO: set_v[7:0]        = set_v[7:0] | wdata_i;
        `ADDR_FORCE_HI: set_v[15:8]       = set_v[15:8] | wdata_i;
        `ADDR_MODE0:    st_nxt.mode0      = wdata_i;
        `ADDR_MODE1:    st_nxt.done       = wdata_i[`MODE1_DONE];
        `ADDR_MODE2:    st_nxt.mode2      = wdata_i;
        default: ;
      endcase
    end
    // set wins over acknowledge
    st_nxt.req = (st_r.req & ~clr_v) | set_v;

    st_nxt.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        `ADDR_MASK_LO:  st_nxt.rdata = st_r.mask[7:0];
        `ADDR_MASK_HI:  st_nxt.rdata = st_r.mask[15:8];
        `ADDR_MODE0:    st_nxt.rdata = st_r.mode0;
        `ADDR_MODE2:    st_nxt.rdata = st_r.mode2;
        `ADDR_REQ_LO:   st_nxt.rdata = st_r.req[7:0];
        `ADDR_REQ_HI:   st_nxt.rdata = st_r.req[15:8];
        `ADDR_ACT_LO:   st_nxt.rdata = active_irq[7:0];
        `ADDR_ACT_HI:   st_nxt.rdata = active_irq[15:8];
        `ADDR_STAT_LO:  st_nxt.rdata = status_word[7:0];
        `ADDR_STAT_HI:  st_nxt.rdata = status_word[15:8];
        default:        st_nxt.rdata = 8'h00;
      endcase
    end

    // outputs held inactive while done is pending or the gap runs
    st_nxt.common_pin = ((common_any && !gap_busy && !st_r.done) ~^ pol);
    st_nxt.ic_pin     = ((ic_any && !gap_busy && !st_r.done) ~^ pol);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r            <= '0;
      st_r.mask       <= `MASK_RESET;
      st_r.mode0      <= `MODE0_RESET;
      st_r.mode2      <= `MODE2_RESET;
      st_r.common_pin <= 1'b1;
      st_r.ic_pin     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o            = st_r.rdata;
  assign common_irq_pin_o   = st_r.common_pin;
  assign ind_conf_irq_pin_o = st_r.ic_pin;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_ack_set_wins: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (event_i[0]) |=> st_r.req[0])
    else $error("event lost against acknowledge");

  a_ack_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && hit(addr_i, `ADDR_ACK_LO) && wdata_i[0] && !event_i[0]) |=> !st_r.req[0])
    else $error("acknowledge did not clear request");

  a_force_sets: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && hit(addr_i, `ADDR_FORCE_HI) && wdata_i[7]) |=> st_r.req[15])
    else $error("forced request not set");

  a_status_ro: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_HI)) |=> rdata_o == $past(status_word[15:8]))
    else $error("status high byte read wrong");

  a_done_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.done |=> (common_irq_pin_o == !st_r.mode0[`MODE0_POLARITY]) [*2])
    else $error("output active right after end of interrupt");

  // a second end of interrupt written back to back legally re-arms the pulse
  a_done_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_r.done && !(wr_i && hit(addr_i, `ADDR_MODE1) && wdata_i[`MODE1_DONE])) |=> !st_r.done)
    else $error("done command did not self clear");

  a_mask_blocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_r.mask == 16'hffff) |-> active_irq == 16'h0000)
    else $error("masked event reached interrupt register");

  a_sep_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!sep_mode) |-> !ic_any)
    else $error("second output used outside separate mode");

  a_common_rise: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (common_any && !gap_busy && !st_r.done) |=>
      common_irq_pin_o == $past(st_r.mode0[`MODE0_POLARITY]))
    else $error("common output not asserted");

  a_done_cmd: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && hit(addr_i, `ADDR_MODE1) && wdata_i[`MODE1_DONE]) |=> st_r.done)
    else $error("end of interrupt command not taken");

  a_gap_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (gap_busy || st_r.done) |=> common_irq_pin_o != $past(st_r.mode0[`MODE0_POLARITY]))
    else $error("common output active inside inactive period");

  a_ic_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (gap_busy || st_r.done) |=> ind_conf_irq_pin_o != $past(st_r.mode0[`MODE0_POLARITY]))
    else $error("second output active inside inactive period");

  a_gap_short_busy: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_r.done && !st_r.mode2[`MODE2_GAP_SEL]) |-> ##50 gap_busy)
    else $error("short inactive period ended early");

  // a restart with the short setting cuts the period to 50 cycles; otherwise this holds for any long setting from 200 to 65535 (the counter is 16 bits wide)
  a_gap_long_busy: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_r.done && st_r.mode2[`MODE2_GAP_SEL]) |-> ##200 gap_busy)
    else $error("long inactive period ended early");

  a_ic_rise: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ic_any && !gap_busy && !st_r.done) |=>
      ind_conf_irq_pin_o == $past(st_r.mode0[`MODE0_POLARITY]))
    else $error("second output not asserted");

  a_masked_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_r.mask == `MASK_RESET) |=> common_irq_pin_o != $past(st_r.mode0[`MODE0_POLARITY]))
    else $error("common output active with every event masked");

  a_mask_lo_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && hit(addr_i, `ADDR_MASK_LO)) |=> st_r.mask[7:0] == $past(wdata_i))
    else $error("mask low byte not written");

  a_mask_hi_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_i && hit(addr_i, `ADDR_MASK_HI)) |=> st_r.mask[15:8] == $past(wdata_i))
    else $error("mask high byte not written");

  a_act_lo_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_ACT_LO)) |=> rdata_o == $past(st_r.req[7:0] & ~st_r.mask[7:0]))
    else $error("active low byte read wrong");

  a_act_hi_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_ACT_HI)) |=> rdata_o == $past(st_r.req[15:8] & ~st_r.mask[15:8]))
    else $error("active high byte read wrong");

  a_stat_lo_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_LO)) |=> rdata_o == $past(status_word[7:0]))
    else $error("status low byte read wrong");

  a_stat_ready_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_LO)) |=> rdata_o[7] == $past(early_ready_i))
    else $error("early ready bit wrong");

  a_stat_recv_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_LO)) |=> rdata_o[6] == $past(recv_en_i))
    else $error("receiver bit wrong");

  a_stat_idle_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_LO)) |=> rdata_o[5:4] == $past(idle_sel_i))
    else $error("idle selection bits wrong");

  a_stat_mac_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_LO)) |=> rdata_o[3:0] == (4'h8 >> $past(mac_state_i)))
    else $error("controller state bits wrong");

  a_stat_stn_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_HI)) |=> rdata_o[7:6] == $past(stn_type_i))
    else $error("station type bits wrong");

  a_stat_latch_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_HI)) |=> rdata_o[5:4] == {$past(conf_latched_i), $past(ind_latched_i)})
    else $error("latched confirmation or indication bit wrong");

  a_stat_prio_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_HI)) |=> rdata_o[3] == $past(high_prio_i))
    else $error("priority bit wrong");

  a_stat_timer_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_HI)) |=> rdata_o[2] == $past(sync_idle_sel_i))
    else $error("timer selection bit wrong");

  a_stat_gap_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && hit(addr_i, `ADDR_STAT_HI)) |=> rdata_o[1:0] == {$past(gap_update_latched_i), $past(mem_lock_i)})
    else $error("gap update or memory lock bit wrong");

  // every request bit latches, clears and is forced alike
  for (genvar k = 0; k < 16; k++) begin : g_req_bits
    a_event_latch: assert property (@(posedge clk_i) disable iff (!nrst_i)
      event_i[k] |=> st_r.req[k])
      else $error("event not latched in request");

    a_ack_bit_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_i && hit(addr_i, (k < 8) ? `ADDR_ACK_LO : `ADDR_ACK_HI) && wdata_i[k % 8] && !event_i[k]) |=>
        !st_r.req[k])
      else $error("acknowledge did not clear request bit");

    a_force_bit_sets: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_i && hit(addr_i, (k < 8) ? `ADDR_FORCE_LO : `ADDR_FORCE_HI) && wdata_i[k % 8]) |=>
        st_r.req[k])
      else $error("forced request bit not set");
  end

endmodule : token_mac_status_and_irq_ctrl

`default_nettype wire

/* token_irq_regs.svh */
`ifndef TOKEN_IRQ_REGS_SVH
`define TOKEN_IRQ_REGS_SVH

// register byte addresses
`define ADDR_MASK_LO      10'h000
`define ADDR_MASK_HI      10'h001
`define ADDR_ACK_LO       10'h002
`define ADDR_ACK_HI       10'h003
`define ADDR_MODE0        10'h004
`define ADDR_MODE1        10'h006
`define ADDR_MODE2        10'h019
`define ADDR_REQ_LO       10'h01a
`define ADDR_REQ_HI       10'h01b
`define ADDR_ACT_LO       10'h01c
`define ADDR_ACT_HI       10'h01d
`define ADDR_STAT_LO      10'h01e
`define ADDR_STAT_HI      10'h01f
`define ADDR_FORCE_LO     10'h020
`define ADDR_FORCE_HI     10'h021

// field positions
`define MODE0_SEP_IRQ     1
`define MODE0_POLARITY    0
`define MODE1_DONE        1
`define MODE2_GAP_SEL     1
`define EVT_IND           15
`define EVT_CONF          14

// reset values
`define MASK_RESET        16'hffff
`define MODE0_RESET       8'h00
`define MODE2_RESET       8'h00

// timing
`define CLK_PERIOD_NS     20
`define GAP_SHORT_NS      1000
`define GAP_LONG_NS       1000000
`define GAP_SHORT_CYC     (`GAP_SHORT_NS / `CLK_PERIOD_NS)
`define GAP_LONG_CYC      (`GAP_LONG_NS / `CLK_PERIOD_NS)

`endif

/* token_irq_pkg.sv */
package token_irq_pkg;
  typedef enum logic [1:0] {
    IDLE_SYNC,
    IDLE_READY,
    IDLE_FIRST,
    IDLE_SECOND
  } idle_sel_t;

  typedef enum logic [1:0] {
    STN_PASSIVE,
    STN_NOT_READY,
    STN_READY,
    STN_IN_RING
  } stn_type_t;

  typedef enum logic [1:0] {
    MAC_HOLD,
    MAC_NOT_HOLD,
    MAC_LISTEN,
    MAC_OFFLINE
  } mac_state_t;
endpackage : token_irq_pkg

/* irq_gap_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "token_irq_regs.svh"

module irq_gap_timer #(
  parameter int unsigned LONG_CYC = `GAP_LONG_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  input  wire logic long_sel_i,
  output logic      busy_o
);
  localparam logic [15:0] SHORT_LD = 16'(`GAP_SHORT_CYC);
  localparam logic [15:0] LONG_LD  = 16'(LONG_CYC);

  typedef struct packed {
    logic [15:0] cnt;
  } gap_state_t;

  gap_state_t st_r;
  gap_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start_i) begin
      st_nxt.cnt = long_sel_i ? LONG_LD : SHORT_LD;
    end else if (st_r.cnt != 16'h0000) begin
      st_nxt.cnt = st_r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = (st_r.cnt != 16'h0000);
endmodule : irq_gap_timer

`default_nettype wire

/* host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "token_irq_regs.svh"

module host_model (
  // clock
  input  wire logic       clk_i,
  // register port
  output logic [9:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    addr_o  = 10'h000;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1 d = rdata_i;
  endtask : rd

  // stale requests would fire at once, so they are cleared before unmasking
  task automatic unmask(input logic [15:0] m);
    wr(`ADDR_ACK_LO, m[7:0]);
    wr(`ADDR_ACK_HI, m[15:8]);
    wr(`ADDR_MASK_LO, ~m[7:0]);
    wr(`ADDR_MASK_HI, ~m[15:8]);
  endtask : unmask

  task automatic done();
    wr(`ADDR_MODE1, 8'h02);
  endtask : done
endmodule : host_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "token_irq_regs.svh"

module tb;
  import token_irq_pkg::*;
  logic       clk_i, nrst_i, wr, rd, er, rv, cf, nd, hp, sy, gp, ml, com_pin, ind_pin;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [15:0] ev;
  idle_sel_t  idl;
  mac_state_t mac;
  stn_type_t  stn;
  int         fails, comparisons, c;

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  // long gap shortened so the 1 ms case stays cheap
  token_mac_status_and_irq_ctrl #(.GAP_LONG_CYC(200)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .early_ready_i(er), .recv_en_i(rv), .idle_sel_i(idl), .mac_state_i(mac), .stn_type_i(stn),
    .conf_latched_i(cf), .ind_latched_i(nd), .high_prio_i(hp), .sync_idle_sel_i(sy),
    .gap_update_latched_i(gp), .mem_lock_i(ml), .event_i(ev),
    .common_irq_pin_o(com_pin), .ind_conf_irq_pin_o(ind_pin));

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [9:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(n, {8'h00, d}, {8'h00, e});
  endtask : rchk

  task automatic pulse(input logic [15:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 16'h0000;
  endtask : pulse

  // counts cycles until the chosen pin reaches lvl
  task automatic wait_pin(input bit ind, input logic lvl, output int n);
    n = 0;
    while (((ind ? ind_pin : com_pin) !== lvl) && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 300) begin
      fails++;
      report_and_stop();
    end
  endtask : wait_pin

  initial begin
    {nrst_i, er, rv, cf, nd, hp, sy, gp, ml} = '0;
    idl = IDLE_SYNC;
    mac = MAC_HOLD;
    stn = STN_PASSIVE;
    ev  = 16'h0000;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    rchk("mask_lo", `ADDR_MASK_LO, 8'hff);
    rchk("mask_hi", `ADDR_MASK_HI, 8'hff);
    rchk("act_lo", `ADDR_ACT_LO, 8'h00);
    rchk("req_hi", `ADDR_REQ_HI, 8'h00);
    rchk("unmapped", 10'h100, 8'h00);
    chk("pins", {com_pin, ind_pin}, 16'h3);
    $display("test reset done");
    @(posedge clk_i);
    {er, rv, cf, nd, hp, sy, gp, ml} <= 8'haa;
    idl <= IDLE_FIRST;
    stn <= STN_READY;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      mac <= mac_state_t'(s);
      rchk("stat_lo", `ADDR_STAT_LO, {4'ha, 4'h8 >> s});
    end
    rchk("stat_hi", `ADDR_STAT_HI, 8'haa);
    @(posedge clk_i);
    {er, rv, cf, nd, hp, sy, gp, ml} <= 8'h55;
    idl <= IDLE_READY;
    stn <= STN_NOT_READY;
    host.wr(`ADDR_STAT_LO, 8'hff);
    host.wr(`ADDR_STAT_HI, 8'h00);
    rchk("stat_lo", `ADDR_STAT_LO, 8'h51);
    rchk("stat_hi", `ADDR_STAT_HI, 8'h55);
    $display("test status done");
    pulse(16'h00fc);
    rchk("req_lo", `ADDR_REQ_LO, 8'hfc);
    rchk("act_lo", `ADDR_ACT_LO, 8'h00);
    chk("com_pin", com_pin, 1'b1);
    host.wr(`ADDR_ACK_LO, 8'hfc);
    rchk("req_lo", `ADDR_REQ_LO, 8'h00);
    host.wr(`ADDR_FORCE_HI, 8'h80);
    rchk("req_hi", `ADDR_REQ_HI, 8'h80);
    $display("test request done");
    host.unmask(16'h0001);
    pulse(16'h0003);
    wait_pin(0, 1'b0, c);
    rchk("act_lo", `ADDR_ACT_LO, 8'h01);
    host.wr(`ADDR_MODE0, 8'h01);
    wait_pin(0, 1'b1, c);
    host.wr(`ADDR_MODE0, 8'h00);
    $display("test unmask done");
    for (int g = 0; g < 2; g++) begin
      host.wr(`ADDR_MODE2, g ? 8'h02 : 8'h00);
      host.done();
      wait_pin(0, 1'b1, c);
      wait_pin(0, 1'b0, c);
      chk("gap", 16'(c >= (g ? 196 : 46) && c <= (g ? 206 : 56)), 16'h1);
    end
    $display("test gap done");
    fork
      host.wr(`ADDR_ACK_LO, 8'h01);
      pulse(16'h0001);
    join
    rchk("req_lo", `ADDR_REQ_LO, 8'h03);
    host.wr(`ADDR_ACK_LO, 8'h01);
    rchk("req_lo", `ADDR_REQ_LO, 8'h02);
    $display("test ack done");
    host.wr(`ADDR_MODE0, 8'h02);
    host.unmask(16'h8000);
    pulse(16'h8000);
    wait_pin(1, 1'b0, c);
    chk("com_pin", com_pin, 1'b1);
    host.wr(`ADDR_MODE0, 8'h03);
    wait_pin(1, 1'b1, c);
    $display("test separate done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
